/* File: verilog/agc_pkg.sv */
/*
 Shared constants of the gain control and serial control block:
 register indices, field positions, reset values, timing figures.
 Assumes a single 250 MHz clock.
*/
package agc_pkg;
   localparam int CLK_MHZ = 250;
   // Register indices; byte address on the register bus is four times these
   localparam logic [7:0] REG_CTRL = 8'h01;
   localparam logic [7:0] REG_ATTACK = 8'h02;
   localparam logic [7:0] REG_RELEASE = 8'h03;
   localparam logic [7:0] REG_HOLD = 8'h04;
   localparam logic [7:0] REG_FIXED = 8'h05;
   localparam logic [7:0] REG_LIMIT = 8'h06;
   localparam logic [7:0] REG_MAXGAIN = 8'h07;
   localparam logic [7:0] REG_RST [1:7] = '{8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a, 8'hc2};
   // Control register fields
   localparam int CTRL_SPK_R = 7;
   localparam int CTRL_SPK_L = 6;
   localparam int CTRL_SWS = 5;
   localparam int CTRL_FLT_R = 4;
   localparam int CTRL_FLT_L = 3;
   localparam int CTRL_NG_EN = 0;
   localparam int TIME_W = 6;
   localparam int MAXG_LSB = 4;
   // Serial slave address, seven bits
   localparam logic [6:0] DEV_ADDR = 7'h58;
   // Gain in half-decibel steps, signed
   localparam logic signed [7:0] GAIN_START = 8'sh00;
   localparam logic signed [7:0] GAIN_MIN = -8'sh38;
   // Timer unit and output stage delay
   localparam int TICK_US = 10;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int STARTUP_MS = 2;
   localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: verilog/gain_timer.sv */
/*
 One gain control interval timer, counting down in timer ticks.
 Assumes tick is a one-cycle enable from a divider on the same clock.
*/
`timescale 1ns/100ps
module gain_timer (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic tick,
   input wire logic [5:0] dur,
   output logic done
);
   logic [5:0] cnt_q;

   always_ff @(posedge ref_clk) begin
      if (srst || restart) begin
         cnt_q <= dur;
      end else if (tick && cnt_q != 6'h00) begin
         cnt_q <= cnt_q - 6'h01;
      end
   end

   assign done = (cnt_q == 6'h00);
endmodule // gain_timer

/* File: verilog/serial_slave.sv */
/*
 Two-wire serial slave with a register pointer that advances per byte.
 Assumes scl and sda come straight from pins; the data line is open drain.
*/
`timescale 1ns/100ps
module serial_slave (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe,
   output logic wr_en,
   output logic [7:0] wr_idx,
   output logic [7:0] wr_data,
   output logic [7:0] rd_idx,
   input wire logic [7:0] rd_data
);
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} st_t;
   typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} kind_t;
   st_t st_q;
   kind_t kind_q;
   logic [1:0] scl_s1, sda_s1;
   logic scl_s2, sda_s2, scl_p, sda_p;
   logic [7:0] sh_q, ptr_q;
   logic [3:0] cnt_q;
   logic rw_q, nack_q;

   always_ff @(posedge ref_clk) begin
      scl_s1 <= {scl_s1[0], scl_in};
      sda_s1 <= {sda_s1[0], sda_in};
      scl_p <= scl_s1[1];
      sda_p <= sda_s1[1];
   end
   assign scl_s2 = scl_s1[1];
   assign sda_s2 = sda_s1[1];

   wire rise = scl_s2 && !scl_p;
   wire fall = !scl_s2 && scl_p;
   wire start_c = scl_s2 && scl_p && sda_p && !sda_s2;
   wire stop_c = scl_s2 && scl_p && !sda_p && sda_s2;
   wire addr_hit = (sh_q[7:1] == agc_pkg::DEV_ADDR);

   assign rd_idx = ptr_q;
   assign wr_idx = ptr_q;
   assign wr_data = sh_q;

   always_ff @(posedge ref_clk) begin
      wr_en <= 1'b0;
      if (srst || stop_c) begin
         st_q <= ST_IDLE;
         sda_oe <= 1'b0;
         cnt_q <= 4'h0;
         if (srst) begin
            ptr_q <= 8'h00;
            kind_q <= K_ADDR;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            sh_q <= 8'h00;
         end
      end else if (start_c) begin
         st_q <= ST_RX;
         kind_q <= K_ADDR;
         sda_oe <= 1'b0;
         cnt_q <= 4'h0;
      end else begin
         unique case (st_q)
            ST_IDLE: ;
            ST_RX: begin
               if (rise) begin
                  sh_q <= {sh_q[6:0], sda_s2};
                  cnt_q <= cnt_q + 4'h1;
               end else if (fall && cnt_q == 4'h8) begin
                  cnt_q <= 4'h0;
                  st_q <= ST_ACK;
                  sda_oe <= 1'b1;
                  if (kind_q == K_ADDR) begin
                     rw_q <= sh_q[0];
                     if (!addr_hit) begin
                        st_q <= ST_IDLE;
                        sda_oe <= 1'b0;
                     end
                  end else if (kind_q == K_REG) begin
                     ptr_q <= sh_q;
                  end else begin
                     wr_en <= 1'b1;
                  end
               end
            end
            ST_ACK: begin
               if (fall) begin
                  if (kind_q == K_DATA) begin
                     ptr_q <= ptr_q + 8'h01;
                  end
                  if (kind_q == K_ADDR && rw_q) begin
                     sh_q <= rd_data;
                     ptr_q <= ptr_q + 8'h01;
                     sda_oe <= !rd_data[7];
                     st_q <= ST_TX;
                  end else begin
                     sda_oe <= 1'b0;
                     st_q <= ST_RX;
                     kind_q <= (kind_q == K_ADDR) ? K_REG : K_DATA;
                  end
               end
            end
            ST_TX: begin
               if (fall) begin
                  if (cnt_q == 4'h7) begin
                     sda_oe <= 1'b0;
                     st_q <= ST_RACK;
                     cnt_q <= 4'h0;
                  end else begin
                     cnt_q <= cnt_q + 4'h1;
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe <= !sh_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (rise) begin
                  nack_q <= sda_s2;
               end else if (fall) begin
                  if (nack_q) begin
                     st_q <= ST_IDLE;
                  end else begin
                     sh_q <= rd_data;
                     ptr_q <= ptr_q + 8'h01;
                     sda_oe <= !rd_data[7];
                     st_q <= ST_TX;
                  end
               end
            end
         endcase
      end
   end
endmodule // serial_slave

/* File: verilog/agc_control.sv */
/*
 Gain control loop, power sequencing and control registers, reached both
 by the two-wire serial port and by AXI4-Lite. Assumes envelope, fault and
 shutdown inputs arrive asynchronously from pins and analog detectors.
*/
// Overview of operation
// - Below the noise gate threshold, gain does not change.
// - Gain never rises above the programmed maximum gain.
// - Decreases only after the attack timer has expired.
// - Increases only after the release timer has expired.
// - All three timers restart after every gain change.
// - First increase after a decrease waits hold time, if enabled and longer.
// - Hold can be disabled; then release time governs.
// - Later increases are spaced by release time.
// - Shutdown pin high powers up port and logic, stage enables later.
// - Gain starts at zero decibels; ramping waits for the noise gate.
// - Clearing both speaker enables turns off both amplifiers only.
// - Software shutdown bit disables most amplifier functions.
// - Shutdown pin low stops the serial port and output stage and restores register defaults; AXI stays live.
// - Bytes are eight bits, MSB first, each acknowledged.
// - Start and stop are data edges while clock is high.
// - Acknowledge holds the data line low through its clock period.
// - Multi-byte read returns successive registers while master acknowledges.
// - Sequential write starts at received index, then next registers.
// - Any number of bytes between start and stop.
// - Each gain change is one half-decibel step.
`timescale 1ns/100ps
module agc_control #(
   parameter int STARTUP_CYC = agc_pkg::STARTUP_CYC
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic chip_shutdown_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic above_noise_gate,
   input wire logic want_gain_down,
   input wire logic want_gain_up,
   input wire logic fault_right,
   input wire logic fault_left,
   input wire logic thermal_alarm,
   output logic [7:0] gain_half_db,
   output logic output_stage_on,
   output logic right_amp_on,
   output logic left_amp_on,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   // Asynchronous inputs pass two flops before use
   logic [6:0] sync1_q, sync2_q;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {chip_shutdown_n, above_noise_gate, want_gain_down,
                     want_gain_up, fault_right, fault_left, thermal_alarm};
         sync2_q <= sync1_q;
      end
   end
   wire sd_n_s = sync2_q[6];
   wire gate_s = sync2_q[5];
   wire down_s = sync2_q[4];
   wire up_s = sync2_q[3];
   wire flt_r_s = sync2_q[2];
   wire flt_l_s = sync2_q[1];
   wire therm_s = sync2_q[0];

   // Shutdown pin low resets registers and serial port
   wire chip_rst = srst || !sd_n_s;

   // Register file
   logic [7:0] regs_q [1:7];
   logic flt_r_q, flt_l_q;
   logic [7:0] view [0:7];
   logic [7:0] i2c_rd_idx, i2c_wr_idx, i2c_wr_data;
   logic i2c_wr_en;

   wire [7:0] ctrl = regs_q[1];
   wire software_shutdown = ctrl[agc_pkg::CTRL_SWS];
   wire ng_en = ctrl[agc_pkg::CTRL_NG_EN];
   wire [5:0] atk_dur = regs_q[2][5:0];
   wire [5:0] rel_dur = regs_q[3][5:0];
   wire [5:0] hold_dur = regs_q[4][5:0];
   wire [3:0] max_code = regs_q[7][7:agc_pkg::MAXG_LSB];

   always_comb begin
      view[0] = 8'h00;
      view[1] = {ctrl[7:5], flt_r_q, flt_l_q, therm_s, 1'b1, ctrl[0]};
      for (int i = 2; i < 8; i++) begin
         view[i] = regs_q[i];
      end
   end

   wire [7:0] i2c_rd_data = (i2c_rd_idx[7:3] == 5'h00) ? view[i2c_rd_idx[2:0]] : 8'h00;

   serial_slave u_serial (
      .ref_clk(ref_clk),
      .srst(chip_rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_oe(sda_oe),
      .wr_en(i2c_wr_en),
      .wr_idx(i2c_wr_idx),
      .wr_data(i2c_wr_data),
      .rd_idx(i2c_rd_idx),
      .rd_data(i2c_rd_data)
   );
   // Open drain: only ever pulls low
   assign sda_out = 1'b0;

   // AXI4-Lite slave; index = byte address / 4
   logic aw_have_q, w_have_q;
   logic [7:0] aw_q;
   logic [7:0] w_q;
   logic w_strb_q;
   wire [2:0] aw_idx = aw_q[4:2];
   wire aw_ok = (aw_q[7:5] == 3'h0) && (aw_idx != 3'h0);
   wire [2:0] ar_idx = araddr[4:2];
   wire ar_ok = (araddr[7:5] == 3'h0) && (ar_idx != 3'h0);
   // Serial writes take the port first; bus write waits a cycle
   wire axi_do = aw_have_q && w_have_q && !bvalid && !i2c_wr_en;
   wire axi_wr = axi_do && aw_ok && w_strb_q;

   assign awready = !aw_have_q && !bvalid;
   assign wready = !w_have_q && !bvalid;
   assign arready = !rvalid;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 8'h00;
         w_strb_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= agc_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            w_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
         end
         if (axi_do) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= aw_ok ? agc_pkg::RESP_OKAY : agc_pkg::RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= agc_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, ar_ok ? view[ar_idx] : 8'h00};
         rresp <= ar_ok ? agc_pkg::RESP_OKAY : agc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // Merged write port
   wire wr_en = i2c_wr_en || axi_wr;
   wire [7:0] wr_idx = i2c_wr_en ? i2c_wr_idx : {5'h00, aw_idx};
   wire [7:0] wr_data = i2c_wr_en ? i2c_wr_data : w_q;
   wire wr_hit = wr_en && wr_idx >= agc_pkg::REG_CTRL && wr_idx <= agc_pkg::REG_MAXGAIN;
   wire wr_ctrl = wr_en && wr_idx == agc_pkg::REG_CTRL;

   always_ff @(posedge ref_clk) begin
      if (chip_rst) begin
         for (int i = 1; i < 8; i++) begin
            regs_q[i] <= agc_pkg::REG_RST[i];
         end
      end else if (wr_hit) begin
         regs_q[wr_idx[2:0]] <= wr_data;
      end
   end

   // Fault flags: writing 0 clears, a new fault in the same cycle wins
   always_ff @(posedge ref_clk) begin
      if (chip_rst) begin
         flt_r_q <= agc_pkg::REG_RST[1][agc_pkg::CTRL_FLT_R];
         flt_l_q <= agc_pkg::REG_RST[1][agc_pkg::CTRL_FLT_L];
      end else begin
         flt_r_q <= flt_r_s || (flt_r_q && !(wr_ctrl && !wr_data[agc_pkg::CTRL_FLT_R]));
         flt_l_q <= flt_l_s || (flt_l_q && !(wr_ctrl && !wr_data[agc_pkg::CTRL_FLT_L]));
      end
   end

   // Power sequencing; relies on the controller not cutting a sequence short
   logic [31:0] up_cnt_q;
   wire powered = sd_n_s && !software_shutdown;
   always_ff @(posedge ref_clk) begin
      if (srst || !powered) begin
         up_cnt_q <= 32'h0000_0000;
         output_stage_on <= 1'b0;
      end else if (up_cnt_q == 32'(STARTUP_CYC - 1)) begin
         output_stage_on <= 1'b1;
      end else begin
         up_cnt_q <= up_cnt_q + 32'h0000_0001;
      end
   end

   assign right_amp_on = output_stage_on && ctrl[agc_pkg::CTRL_SPK_R];
   assign left_amp_on = output_stage_on && ctrl[agc_pkg::CTRL_SPK_L];

   // Timer tick divider
   logic [15:0] tick_cnt_q;
   logic tick_q;
   // Wrap on the last count, so ticks are exactly TICK_CYC apart
   wire tick_wrap = (tick_cnt_q == 16'(agc_pkg::TICK_CYC - 1));
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tick_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick_wrap;
         tick_cnt_q <= tick_wrap ? 16'h0000 : tick_cnt_q + 16'h0001;
      end
   end

   // Gain control loop
   logic signed [7:0] gain_q;
   logic after_dec_q;
   logic atk_done, rel_done, hold_done;
   wire gate_open = !ng_en || gate_s;
   wire signed [7:0] cap = $signed({2'b00, max_code, 2'b00});
   wire use_hold = after_dec_q && hold_dur != 6'h00 && hold_dur > rel_dur;
   wire inc_wait = use_hold ? hold_done : rel_done;
   wire do_dec = output_stage_on && gate_open && down_s && atk_done && gain_q > agc_pkg::GAIN_MIN;
   wire do_inc = output_stage_on && gate_open && up_s && !down_s && inc_wait && gain_q < cap;
   wire change = do_dec || do_inc;
   wire tmr_restart = change || !output_stage_on;

   gain_timer u_attack (
      .ref_clk(ref_clk),
      .srst(srst),
      .restart(tmr_restart),
      .tick(tick_q),
      .dur(atk_dur),
      .done(atk_done)
   );
   gain_timer u_release (
      .ref_clk(ref_clk),
      .srst(srst),
      .restart(tmr_restart),
      .tick(tick_q),
      .dur(rel_dur),
      .done(rel_done)
   );
   gain_timer u_hold (
      .ref_clk(ref_clk),
      .srst(srst),
      .restart(tmr_restart),
      .tick(tick_q),
      .dur(hold_dur),
      .done(hold_done)
   );

   always_ff @(posedge ref_clk) begin
      if (srst || !output_stage_on) begin
         gain_q <= agc_pkg::GAIN_START;
         after_dec_q <= 1'b0;
      end else if (do_dec) begin
         gain_q <= gain_q - 8'sh01;
         after_dec_q <= 1'b1;
      end else if (do_inc) begin
         gain_q <= gain_q + 8'sh01;
         after_dec_q <= 1'b0;
      end
   end

   assign gain_half_db = gain_q;
endmodule // agc_control

/* File: verif/agc_control_checker.sv */
/*
 Port-level checks on agc_control: gain steps, power modes, serial data timing, AXI.
 Assumes one clock domain with synchronous active-high srst.
*/
`timescale 1ns/100ps
module agc_control_checker #(
   parameter int STARTUP_CYC = 20
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic chip_shutdown_n,
   input wire logic scl_in,
   input wire logic sda_oe,
   input wire logic above_noise_gate,
   input wire logic [7:0] gain_half_db,
   input wire logic output_stage_on,
   input wire logic right_amp_on,
   input wire logic left_amp_on,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Raw pin count; the synchronizer only adds margin
   int hi_cnt_q;
   always_ff @(posedge ref_clk) begin
      if (srst || !chip_shutdown_n) hi_cnt_q <= 0;
      else if (hi_cnt_q < STARTUP_CYC) hi_cnt_q <= hi_cnt_q + 1;
   end
   property p_step;
      output_stage_on && $past(output_stage_on) && !$stable(gain_half_db) |->
         8'(gain_half_db - $past(gain_half_db)) == 8'h01 ||
         8'($past(gain_half_db) - gain_half_db) == 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("gain moved more than one step");
   property p_gate;
      !above_noise_gate [*6] ##0 output_stage_on |=> $stable(gain_half_db) || !output_stage_on;
   endproperty
   a_gate: assert property (p_gate) else $error("gain moved below gate");
   property p_rise_zero;
      $rose(output_stage_on) |-> gain_half_db == 8'h00;
   endproperty
   a_rise_zero: assert property (p_rise_zero) else $error("start gain not zero");
   property p_startup;
      $rose(output_stage_on) |-> hi_cnt_q >= STARTUP_CYC;
   endproperty
   a_startup: assert property (p_startup) else $error("output stage on too early");
   property p_pin_off;
      !chip_shutdown_n [*4] |=> !output_stage_on;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("stage on in shutdown");
   property p_amps;
      right_amp_on || left_amp_on |-> output_stage_on;
   endproperty
   a_amps: assert property (p_amps) else $error("amp on without stage");
   property p_sda;
      $changed(sda_oe) |-> !scl_in && !$past(scl_in);
   endproperty
   a_sda: assert property (p_sda) else $error("sda moved with scl high");
   property p_bhold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule // agc_control_checker
bind agc_control agc_control_checker #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
   .ref_clk, .srst, .chip_shutdown_n, .scl_in, .sda_oe, .above_noise_gate, .gain_half_db,
   .output_stage_on, .right_amp_on, .left_amp_on, .bresp, .bvalid, .bready, .rdata,
   .rvalid, .rready
);

/* File: verif/serial_master.sv */
/*
 Two-wire bus master model, one bit per 12 ref_clk cycles (48 ns).
 Assumes sda_line is the wired-AND bus level with a pull-up.
*/
`timescale 1ns/100ps
module serial_master (
   input wire logic ref_clk,
   input wire logic sda_line,
   output logic scl,
   output logic pull
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Data moves 2 cycles clear of scl edges, so synced copies never look like start
   task automatic bit_c(input logic b, output logic r);
      w(2);
      pull <= !b;
      w(4);
      scl <= 1'b1;
      w(6);
      r = sda_line;
      scl <= 1'b0;
   endtask
   task automatic start_c();
      w(2);
      pull <= 1'b0;
      w(4);
      scl <= 1'b1;
      w(6);
      pull <= 1'b1;
      w(6);
      scl <= 1'b0;
   endtask
   task automatic stop_c();
      w(2);
      pull <= 1'b1;
      w(4);
      scl <= 1'b1;
      w(6);
      pull <= 1'b0;
      w(6);
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_c(b[i], r);
      bit_c(1'b1, r);
      ack = !r;
   endtask
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
      bit_c(last, r);
   endtask
endmodule // serial_master

/* File: verif/tb_top.sv */
/*
 Self-checking bench for agc_control: registers, serial port, gain timing, power.
 Assumes agc_pkg, serial_master and the checker are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
   localparam int TK = agc_pkg::TICK_CYC;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic chip_shutdown_n = 1'b1;
   logic above_noise_gate = 1'b0;
   logic want_gain_down = 1'b0;
   logic want_gain_up = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic scl, pull, sda_out, sda_oe, awready, wready, bvalid, arready, rvalid;
   logic output_stage_on, right_amp_on, left_amp_on;
   logic [7:0] gain_half_db;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   wire sda_line = !(pull | (sda_oe & !sda_out));
   int n_errors = 0;
   int comparisons = 0;
   agc_control #(.STARTUP_CYC(20)) DUT (
      .ref_clk, .srst, .chip_shutdown_n, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
      .above_noise_gate, .want_gain_down, .want_gain_up, .fault_right(1'b0),
      .fault_left(1'b0), .thermal_alarm(1'b0), .gain_half_db, .output_stage_on,
      .right_amp_on, .left_amp_on, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready
   );
   serial_master peer (.ref_clk, .sda_line, .scl, .pull);
   initial forever #2 ref_clk = ~ref_clk;
   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Cycles until the gain moves, or lim if it holds
   task automatic step(output int c, input int lim);
      logic [7:0] g;
      g = gain_half_db;
      c = 0;
      while (gain_half_db === g && c < lim) begin
         @(posedge ref_clk);
         c++;
      end
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 1; i <= 7; i++) begin
         axi_rd(8'(i * 4), d, r);
         chk(d === {24'h0, agc_pkg::REG_RST[i]} && r === agc_pkg::RESP_OKAY, "default");
      end
      axi_rd(8'h20, d, r);
      chk(r === agc_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
      axi_wr(8'h00, 8'h55, r);
      chk(r === agc_pkg::RESP_SLVERR, "unmapped write");
      $display("regs done");
   endtask
   task automatic t_serial();
      logic a;
      logic [7:0] d;
      logic [31:0] v;
      logic [1:0] r;
      // Attack 2, release 2, hold off, cap 0: short enough to time in a run
      logic [7:0] cfg [6] = '{8'h02, 8'h02, 8'h00, 8'h06, 8'h3a, 8'h02};
      peer.start_c();
      peer.wr_byte({agc_pkg::DEV_ADDR, 1'b0}, a);
      chk(a === 1'b1, "addr ack");
      peer.wr_byte(agc_pkg::REG_ATTACK, a);
      chk(a === 1'b1, "index ack");
      foreach (cfg[i]) begin
         peer.wr_byte(cfg[i], a);
         chk(a === 1'b1, "data ack");
      end
      peer.stop_c();
      for (int i = 2; i <= 7; i++) begin
         axi_rd(8'(i * 4), v, r);
         chk(v[7:0] === cfg[i - 2], "seq write");
      end
      peer.start_c();
      peer.wr_byte({agc_pkg::DEV_ADDR, 1'b0}, a);
      peer.wr_byte(agc_pkg::REG_RELEASE, a);
      peer.start_c();
      peer.wr_byte({agc_pkg::DEV_ADDR, 1'b1}, a);
      for (int i = 0; i < 3; i++) begin
         peer.rd_byte(i == 2, d);
         chk(d === cfg[i + 1], "seq read");
      end
      peer.stop_c();
      peer.start_c();
      peer.wr_byte(8'ha0, a);
      chk(a === 1'b0, "foreign addr");
      peer.stop_c();
      $display("serial done");
   endtask
   task automatic t_gain();
      int c;
      logic [1:0] r;
      // Timers latch their duration at restart: program hold before the decreases
      axi_wr(8'h10, 8'h04, r);
      above_noise_gate <= 1'b1;
      want_gain_down <= 1'b1;
      step(c, 8 * TK);
      for (int i = 0; i < 2; i++) begin
         step(c, 8 * TK);
         chk(c >= TK && c <= 2 * TK + 10, "attack gap");
      end
      chk(gain_half_db === 8'hfd, "three steps down");
      want_gain_down <= 1'b0;
      want_gain_up <= 1'b1;
      step(c, 8 * TK);
      chk(c > 2 * TK + 20 && c <= 4 * TK + 10, "hold first");
      step(c, 8 * TK);
      chk(c >= TK && c <= 2 * TK + 10, "release gap");
      step(c, 8 * TK);
      step(c, 3 * TK);
      chk(c == 3 * TK && gain_half_db === 8'h00, "max gain cap");
      axi_wr(8'h10, 8'h00, r);
      want_gain_up <= 1'b0;
      want_gain_down <= 1'b1;
      step(c, 8 * TK);
      want_gain_down <= 1'b0;
      want_gain_up <= 1'b1;
      step(c, 8 * TK);
      chk(c <= 2 * TK + 10, "no hold");
      want_gain_up <= 1'b0;
      want_gain_down <= 1'b1;
      above_noise_gate <= 1'b0;
      step(c, 3 * TK);
      chk(c == 3 * TK, "gate freeze");
      above_noise_gate <= 1'b1;
      step(c, 3 * TK);
      chk(c < 3 * TK, "gate resume");
      want_gain_down <= 1'b0;
      $display("gain done");
   endtask
   task automatic t_power();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(8'h04, 8'h03, r);
      repeat (4) @(posedge ref_clk);
      chk(output_stage_on === 1'b1 && {right_amp_on, left_amp_on} === 2'b00, "spk off");
      axi_wr(8'h04, 8'he3, r);
      repeat (4) @(posedge ref_clk);
      chk(output_stage_on === 1'b0 && right_amp_on === 1'b0, "sws");
      axi_wr(8'h04, 8'hc3, r);
      repeat (40) @(posedge ref_clk);
      chk(output_stage_on === 1'b1 && gain_half_db === 8'h00, "restart");
      chip_shutdown_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(output_stage_on === 1'b0 && left_amp_on === 1'b0, "pin off");
      chip_shutdown_n <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk(output_stage_on === 1'b1, "pin on");
      axi_rd(8'h08, d, r);
      chk(d === 32'h05, "defaults back");
      $display("power done");
   endtask
   task automatic final_report();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (40) @(posedge ref_clk);
      t_regs();
      t_serial();
      t_gain();
      t_power();
      final_report();
   end
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_errors++;
      $display("[ERR] %0t watchdog", $time);
      final_report();
   end
endmodule // tb_top
